// ### mcem_consts.svh
`ifndef MCEM_CONSTS_SVH
`define MCEM_CONSTS_SVH

// two-wire bus device address and register offsets
`define MCEM_DEV_ADDR 7'h50
`define MCEM_OFS_STATUS 8'h02
`define MCEM_OFS_LOL 8'h05
`define MCEM_OFS_CDR 8'h62
`define MCEM_OFS_PAGE 8'h7f
`define MCEM_OFS_TX_EQ 8'hea
`define MCEM_OFS_RX_EMPH 8'hec
`define MCEM_OFS_RX_AMP 8'hee
`define MCEM_UPPER_BASE 8'h80
`define MCEM_CODE_PAGE 8'h03
`define MCEM_CODE_BYTES 8'h06

// field positions and reset values
`define MCEM_DNR_BIT 0
`define MCEM_RST_BYTE 8'h00
`define MCEM_RST_CODES 16'h0000

// highest code that selects a setting, per field
`define MCEM_MAX_AMP 4'h3
`define MCEM_MAX_EQ 4'ha
`define MCEM_MAX_EMPH 4'h7

// timing
`define MCEM_CLK_MHZ 40
`define MCEM_INIT_TIME_MS 2000
`define MCEM_INIT_CYCLES (`MCEM_INIT_TIME_MS * 1000 * `MCEM_CLK_MHZ)
`define MCEM_RESET_MIN_US 2
`define MCEM_RESET_MIN_CYCLES (`MCEM_RESET_MIN_US * `MCEM_CLK_MHZ)

`endif

// ### mcem_pkg.sv
package mcem_pkg;

  // two-wire slave frame states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR,
    ST_WR_ACK,
    ST_RD,
    ST_RD_ACK
  } mcem_bus_state_type;

  // per-lane bits, laid out as the register byte (tx high nibble, lane 4 first)
  typedef struct packed {
    logic [3:0] tx;
    logic [3:0] rx;
  } mcem_lane_bits_type;

  // applied lane codes, lane 1 in the top nibble of each field
  typedef struct packed {
    logic [15:0] tx_eq;
    logic [15:0] rx_emph;
    logic [15:0] rx_amp;
  } mcem_codes_type;

  // one byte handed from the bus side to the system side
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } mcem_xfer_type;

endpackage : mcem_pkg

// ### mcem_mgmt.sv
`timescale 1ns/100ps
`include "mcem_consts.svh"
// Overview of operation
// - byte 5 bits 7-4: tx lanes 4-1 latched
// - byte 5 bits 3-0: rx lanes 4-1 latched
// - byte 98 bits 7-4 enable tx recovery
// - byte 98 bits 3-0 enable rx recovery
// - amplitude codes 0-3 valid, rest reserved
// - equalization codes 0-10 valid, rest reserved
// - emphasis codes 0-7 valid, rest reserved
// - fully functional within 2000 ms after reset
// - answer serial bus within 2000 ms
// - clear data-not-ready, assert interrupt when ready
// - low-power pin reaches low power within 100 us
// - interrupt asserts within 200 ms of event
// - flags clear on read, starting interrupt release
// - interrupt releases within 500 us after clear
// - functional means interrupt from data-ready
module mcem_mgmt
  import mcem_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = `MCEM_INIT_CYCLES,
  parameter int unsigned RESET_MIN_CYCLES = `MCEM_RESET_MIN_CYCLES
) (
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // two-wire management bus, open drain data
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // module pins
  input wire logic reset_in_n_i,
  input wire logic low_power_pin_i,
  output logic interrupt_out_n_o,
  output logic low_power_o,
  // lane status in, lane controls out
  input wire mcem_lane_bits_type lock_lost_i,
  output mcem_lane_bits_type recovery_enable_o,
  output mcem_codes_type codes_o
);

  localparam int RCW = $clog2(RESET_MIN_CYCLES + 1);

  // ---------------- bus (scl) domain ----------------
  mcem_bus_state_type state_q;
  logic start_tgl_q;
  logic start_seen_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic rd_q;
  logic [7:0] ptr_q;
  logic ptr_set_q;
  logic [7:0] page_m_q;
  logic [7:0] cdr_m_q;
  logic [7:0] code_m_q [6];
  mcem_xfer_type wr_q;
  logic wr_tgl_q;
  mcem_xfer_type cor_q;
  logic cor_tgl_q;
  logic [7:0] flags_m1_q;
  logic [7:0] flags_s_q;
  logic dnr_m1_q;
  logic dnr_s_q;
  // system-side status, declared here since the bus-side sync below reads it
  logic [7:0] flag_q;
  logic dnr_q;
  logic sda_oe_q;
  logic new_frame;
  logic byte_done;
  logic [7:0] byte_in;
  logic load_rd;
  logic upper_ok;
  logic in_codes;
  logic [7:0] code_idx;
  logic [7:0] rd_byte;

  // start marker: scl high while sda falls. read at the next scl rise without a
  // synchroniser, since sda has been stable for a quarter of a bit time by then
  always_ff @(negedge sda_i or posedge rst_i) begin
    if (rst_i) begin
      start_tgl_q <= 1'b0;
    end else if (scl_i) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  assign new_frame = start_tgl_q ^ start_seen_q;
  assign byte_done = (bit_cnt_q == 3'h7);
  assign byte_in = {shift_q[6:0], sda_i};
  assign load_rd = !new_frame &&
                   ((state_q == ST_ADDR_ACK && rd_q) || (state_q == ST_RD_ACK && !sda_i));
  assign upper_ok = (ptr_q < `MCEM_UPPER_BASE) || (page_m_q == `MCEM_CODE_PAGE);
  assign code_idx = ptr_q - `MCEM_OFS_TX_EQ;
  assign in_codes = upper_ok && (ptr_q >= `MCEM_OFS_TX_EQ) && (code_idx < `MCEM_CODE_BYTES);

  // read mux; unmapped bytes and foreign pages read zero
  always_comb begin
    rd_byte = 8'h00;
    if (in_codes) begin
      rd_byte = code_m_q[code_idx[2:0]];
    end else begin
      case (ptr_q)
        `MCEM_OFS_STATUS: rd_byte = {7'h00, dnr_s_q};
        `MCEM_OFS_LOL: rd_byte = flags_s_q;
        `MCEM_OFS_CDR: rd_byte = cdr_m_q;
        `MCEM_OFS_PAGE: rd_byte = page_m_q;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // frame sequencer; always answers its address from reset on
  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      start_seen_q <= 1'b0;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      rd_q <= 1'b0;
    end else if (new_frame) begin
      start_seen_q <= start_tgl_q;
      state_q <= ST_ADDR;
      bit_cnt_q <= 3'h1;
      shift_q <= {7'h00, sda_i};
    end else begin
      case (state_q)
        ST_ADDR: begin
          shift_q <= byte_in;
          bit_cnt_q <= bit_cnt_q + 3'h1;
          if (byte_done) begin
            rd_q <= byte_in[0];
            state_q <= (byte_in[7:1] == `MCEM_DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
          end
        end
        ST_ADDR_ACK, ST_WR_ACK: begin
          bit_cnt_q <= 3'h0;
          if (state_q == ST_ADDR_ACK && rd_q) begin
            state_q <= ST_RD;
            tx_q <= rd_byte;
          end else begin
            state_q <= ST_WR;
          end
        end
        ST_WR: begin
          shift_q <= byte_in;
          bit_cnt_q <= bit_cnt_q + 3'h1;
          if (byte_done) begin
            state_q <= ST_WR_ACK;
          end
        end
        ST_RD: begin
          tx_q <= {tx_q[6:0], 1'b0};
          bit_cnt_q <= bit_cnt_q + 3'h1;
          if (byte_done) begin
            state_q <= ST_RD_ACK;
          end
        end
        ST_RD_ACK: begin
          bit_cnt_q <= 3'h0;
          if (!sda_i) begin
            state_q <= ST_RD;
            tx_q <= rd_byte;
          end else begin
            state_q <= ST_IDLE; // host nack ends the read
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // pointer and bus-side copies of the writable bytes (what reads return)
  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_q <= 8'h00;
      ptr_set_q <= 1'b0;
      page_m_q <= `MCEM_RST_BYTE;
      cdr_m_q <= `MCEM_RST_BYTE;
      for (int i = 0; i < 6; i++) begin
        code_m_q[i] <= `MCEM_RST_BYTE;
      end
    end else if (!new_frame) begin
      if (state_q == ST_ADDR_ACK && !rd_q) begin
        ptr_set_q <= 1'b0;
      end else if (state_q == ST_WR && byte_done) begin
        if (!ptr_set_q) begin
          ptr_q <= byte_in;
          ptr_set_q <= 1'b1;
        end else begin
          ptr_q <= ptr_q + 8'h01;
          if (in_codes) begin
            code_m_q[code_idx[2:0]] <= byte_in; // reserved codes kept as written
          end else if (ptr_q == `MCEM_OFS_CDR) begin
            cdr_m_q <= byte_in;
          end else if (ptr_q == `MCEM_OFS_PAGE) begin
            page_m_q <= byte_in;
          end
        end
      end else if (load_rd) begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  // hand writes and clear-on-read marks to the system side by toggle; the data
  // words stand still for a whole byte time, far longer than the sync delay
  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
      wr_tgl_q <= 1'b0;
      cor_q <= '0;
      cor_tgl_q <= 1'b0;
    end else if (!new_frame) begin
      if (state_q == ST_WR && byte_done && ptr_set_q &&
          (in_codes || ptr_q == `MCEM_OFS_CDR)) begin
        wr_q <= '{addr: ptr_q, data: byte_in};
        wr_tgl_q <= ~wr_tgl_q;
      end
      if (load_rd && (ptr_q == `MCEM_OFS_LOL || ptr_q == `MCEM_OFS_STATUS)) begin
        cor_q <= '{addr: ptr_q, data: rd_byte}; // only bits actually read get cleared
        cor_tgl_q <= ~cor_tgl_q;
      end
    end
  end

  // status levels into the bus domain; bits are independent so per-bit sync is safe
  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      flags_m1_q <= 8'h00;
      flags_s_q <= 8'h00;
      dnr_m1_q <= 1'b1;
      dnr_s_q <= 1'b1;
    end else begin
      flags_m1_q <= flag_q;
      flags_s_q <= flags_m1_q;
      dnr_m1_q <= dnr_q;
      dnr_s_q <= dnr_m1_q;
    end
  end

  // sda changes only while scl is low: ack, then data zeros
  always_ff @(negedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= (state_q == ST_ADDR_ACK) || (state_q == ST_WR_ACK) ||
                  (state_q == ST_RD && !tx_q[7]);
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_q;

  // ---------------- system domain ----------------
  logic [2:0] wr_sync_q;
  logic [2:0] cor_sync_q;
  logic [7:0] lol_m1_q;
  logic [7:0] lol_s_q;
  logic [1:0] pin_m1_q;
  logic [1:0] pin_s_q;
  logic [RCW-1:0] rpin_cnt_q;
  logic init_int_q;
  logic [31:0] init_cnt_q;
  logic int_n_q;
  logic lp_q;
  logic wr_fire;
  logic cor_fire;
  logic pin_hold;
  logic [7:0] clr_mask;
  logic [7:0] cdr_q;
  mcem_codes_type codes_q;
  wire [15:0] eq_d;
  wire [15:0] emph_d;
  wire [15:0] amp_d;

  // synchronisers: toggles, lane status, pins
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_sync_q <= 3'h0;
      cor_sync_q <= 3'h0;
      lol_m1_q <= 8'h00;
      lol_s_q <= 8'h00;
      pin_m1_q <= 2'h1;
      pin_s_q <= 2'h1;
    end else begin
      wr_sync_q <= {wr_sync_q[1:0], wr_tgl_q};
      cor_sync_q <= {cor_sync_q[1:0], cor_tgl_q};
      lol_m1_q <= lock_lost_i;
      lol_s_q <= lol_m1_q;
      pin_m1_q <= {low_power_pin_i, reset_in_n_i};
      pin_s_q <= pin_m1_q;
    end
  end

  assign wr_fire = wr_sync_q[2] ^ wr_sync_q[1];
  assign cor_fire = cor_sync_q[2] ^ cor_sync_q[1];
  assign clr_mask = (cor_fire && cor_q.addr == `MCEM_OFS_LOL) ? cor_q.data : 8'h00;
  assign pin_hold = !pin_s_q[0] && (rpin_cnt_q == RCW'(RESET_MIN_CYCLES));

  // reset pin filter: shorter low pulses are ignored
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rpin_cnt_q <= '0;
    end else if (pin_s_q[0]) begin
      rpin_cnt_q <= '0;
    end else if (!pin_hold) begin
      rpin_cnt_q <= rpin_cnt_q + RCW'(1);
    end
  end

  // latched lock-loss flags; a new loss in the clearing cycle survives
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      flag_q <= 8'h00;
    end else if (pin_hold) begin
      flag_q <= 8'h00;
    end else begin
      flag_q <= (flag_q & ~clr_mask) | lol_s_q;
    end
  end

  // initialisation: data-not-ready drops and raises the interrupt once done
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      init_cnt_q <= 32'h0;
      dnr_q <= 1'b1;
      init_int_q <= 1'b0;
    end else if (pin_hold) begin
      init_cnt_q <= 32'h0;
      dnr_q <= 1'b1;
      init_int_q <= 1'b0;
    end else if (dnr_q) begin
      if (init_cnt_q == INIT_CYCLES - 1) begin
        dnr_q <= 1'b0;
        init_int_q <= 1'b1;
      end else begin
        init_cnt_q <= init_cnt_q + 32'h1;
      end
    end else if (cor_fire && cor_q.addr == `MCEM_OFS_STATUS) begin
      init_int_q <= 1'b0;
    end
  end

  // interrupt and low power follow their causes within a cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      int_n_q <= 1'b1;
      lp_q <= 1'b0;
    end else begin
      int_n_q <= !(init_int_q || (|flag_q));
      lp_q <= pin_s_q[1];
    end
  end

  // per-lane decode: a reserved code leaves the lane setting unchanged
  for (genvar l = 0; l < 4; l++) begin : g_lane
    localparam logic [7:0] BOFS = 8'(l / 2);
    wire [3:0] nib = (l % 2 == 0) ? wr_q.data[7:4] : wr_q.data[3:0];
    assign eq_d[15-4*l -: 4] =
      (wr_fire && wr_q.addr == `MCEM_OFS_TX_EQ + BOFS && nib <= `MCEM_MAX_EQ) ?
      nib : codes_q.tx_eq[15-4*l -: 4];
    assign emph_d[15-4*l -: 4] =
      (wr_fire && wr_q.addr == `MCEM_OFS_RX_EMPH + BOFS && nib <= `MCEM_MAX_EMPH) ?
      nib : codes_q.rx_emph[15-4*l -: 4];
    assign amp_d[15-4*l -: 4] =
      (wr_fire && wr_q.addr == `MCEM_OFS_RX_AMP + BOFS && nib <= `MCEM_MAX_AMP) ?
      nib : codes_q.rx_amp[15-4*l -: 4];
  end

  // applied controls
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cdr_q <= `MCEM_RST_BYTE;
      codes_q <= {`MCEM_RST_CODES, `MCEM_RST_CODES, `MCEM_RST_CODES};
    end else begin
      if (wr_fire && wr_q.addr == `MCEM_OFS_CDR) begin
        cdr_q <= wr_q.data;
      end
      codes_q <= {eq_d, emph_d, amp_d};
    end
  end

  assign interrupt_out_n_o = int_n_q;
  assign low_power_o = lp_q;
  assign recovery_enable_o = cdr_q;
  assign codes_o = codes_q;

  // ---------------- checks ----------------
  a_lol_sets_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    lol_s_q[4] && !pin_hold |=> flag_q[4])
    else $error("tx lane 1 lock loss not latched");
  a_flag_holds: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    flag_q[0] && !clr_mask[0] && !pin_hold |=> flag_q[0])
    else $error("rx lane 1 flag lost without a read");
  a_read_clears: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clr_mask[7] && !lol_s_q[7] |=> !flag_q[7])
    else $error("tx lane 4 flag not cleared by read");
  a_int_asserts: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (|flag_q) |=> !interrupt_out_n_o)
    else $error("interrupt not asserted for latched flag");
  a_int_releases: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !init_int_q && flag_q == 8'h00 |=> interrupt_out_n_o)
    else $error("interrupt not released after clear");
  a_init_ready: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    dnr_q && !pin_hold && init_cnt_q == INIT_CYCLES - 1 |=> !dnr_q ##1 !interrupt_out_n_o)
    else $error("data ready not signalled at end of init");
  a_low_power: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    low_power_pin_i [*4] |=> low_power_o)
    else $error("low power not entered");
  a_amp_reserved: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_fire && wr_q.addr == `MCEM_OFS_RX_AMP && wr_q.data[7:4] > `MCEM_MAX_AMP
    |=> $stable(codes_o.rx_amp[15:12]))
    else $error("reserved amplitude code applied");
  a_eq_valid: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_fire && wr_q.addr == `MCEM_OFS_TX_EQ && wr_q.data[7:4] <= `MCEM_MAX_EQ
    |=> codes_o.tx_eq[15:12] == $past(wr_q.data[7:4]))
    else $error("valid equalization code not applied");
  a_cdr_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_fire && wr_q.addr == `MCEM_OFS_CDR |=> recovery_enable_o == $past(wr_q.data))
    else $error("recovery enables not updated");
  a_write_ack: assert property (@(posedge scl_i) disable iff (rst_i)
    state_q == ST_WR_ACK && !new_frame |-> sda_oe_o && !sda_o)
    else $error("written byte not acknowledged");

endmodule : mcem_mgmt

// ### mcem_host_bfm.sv
`timescale 1ns/100ps
`include "mcem_consts.svh"
// host controller on the two-wire bus; scl runs only inside frames and idles high
module mcem_host_bfm (
  // wire levels
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  localparam realtime QTR = 16.0;

  // idle bus: clock high, data released to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  // one bit: data set a quarter period before scl rises, sampled at the rise
  task automatic clk_bit(input logic b, output logic seen);
    sda_pull_o = ~b;
    #QTR scl_o = 1'b1;
    seen = sda_i;
    #(2 * QTR) scl_o = 1'b0;
    #QTR;
  endtask : clk_bit

  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_pull_o = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR sda_pull_o = 1'b1;
    #QTR scl_o = 1'b0;
    #QTR;
  endtask : start

  // stop leaves both lines high so scl stands still between frames
  task automatic stop();
    sda_pull_o = 1'b1;
    #QTR scl_o = 1'b1;
    #QTR sda_pull_o = 1'b0;
    #QTR;
  endtask : stop

  // msb first, then the device answers in the ninth clock
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : send

  // last byte is answered with a nack, which ends the read
  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      b[i] = s;
    end
    clk_bit(last, s);
  endtask : recv

  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] data, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    start();
    send({`MCEM_DEV_ADDR, 1'b0}, a0);
    send(ofs, a1);
    send(data, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] data, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    start();
    send({`MCEM_DEV_ADDR, 1'b0}, a0);
    send(ofs, a1);
    start();
    send({`MCEM_DEV_ADDR, 1'b1}, a2);
    recv(1'b1, data);
    stop();
    ok = a0 & a1 & a2;
  endtask : read_reg
endmodule : mcem_host_bfm

// ### tb_module_cdr_eq_mgmt.sv
`timescale 1ns/100ps
`include "mcem_consts.svh"
module tb_module_cdr_eq_mgmt import mcem_pkg::*;;
  localparam int INIT = 200;
  typedef struct {
    logic [7:0] ofs;
    logic [7:0] data;
    logic [7:0] en;
    logic [47:0] codes;
  } mcem_tb_row_type;

  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic reset_in_n = 1'b1;
  logic lp_pin = 1'b0;
  mcem_lane_bits_type lock_lost = '0;
  logic scl;
  logic host_pull;
  logic sda_o;
  logic sda_oe;
  logic sda_wire;
  logic int_n;
  logic lp;
  mcem_lane_bits_type rec_en;
  mcem_codes_type codes;
  logic ack;
  int num_errors = 0;
  int tests_run = 0;
  logic [7:0] pats [2] = '{8'h81, 8'h7e};
  // writes and reserved codes; outputs build up from row to row
  mcem_tb_row_type rows [10] = '{
    '{8'h62, 8'hf0, 8'hf0, 48'h0000_0000_0000},
    '{8'h62, 8'h0f, 8'h0f, 48'h0000_0000_0000},
    '{8'h62, 8'ha5, 8'ha5, 48'h0000_0000_0000},
    '{8'hea, 8'ha1, 8'ha5, 48'ha100_0000_0000},
    '{8'heb, 8'hb5, 8'ha5, 48'ha105_0000_0000},
    '{8'hec, 8'h78, 8'ha5, 48'ha105_7000_0000},
    '{8'hed, 8'h12, 8'ha5, 48'ha105_7012_0000},
    '{8'hee, 8'h34, 8'ha5, 48'ha105_7012_3000},
    '{8'hef, 8'h02, 8'ha5, 48'ha105_7012_3002},
    '{8'hee, 8'hc1, 8'ha5, 48'ha105_7012_3102}
  };

  // open-drain data line with a pull-up
  assign sda_wire = ~host_pull & ~(sda_oe & ~sda_o);

  // system clock, 25 ns
  always #12.5 clk_sys_i = ~clk_sys_i;

  mcem_mgmt #(.INIT_CYCLES(INIT)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_wire),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .reset_in_n_i(reset_in_n),
    .low_power_pin_i(lp_pin), .interrupt_out_n_o(int_n), .low_power_o(lp),
    .lock_lost_i(lock_lost), .recovery_enable_o(rec_en), .codes_o(codes)
  );

  mcem_host_bfm host (.sda_i(sda_wire), .scl_o(scl), .sda_pull_o(host_pull));

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
    logic ok;
    host.write_reg(ofs, data, ok);
    check("write ack", 48'(ok), 48'h1);
  endtask : wr

  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp, input string name);
    logic [7:0] d;
    logic ok;
    host.read_reg(ofs, d, ok);
    check("read ack", 48'(ok), 48'h1);
    check(name, 48'(d), 48'(exp));
  endtask : rd

  // bounded wait for the interrupt pin; running out ends the run
  task automatic wait_int(input logic lvl, input int bound);
    int n;
    n = 0;
    while (int_n !== lvl) begin
      @(negedge clk_sys_i);
      n++;
      if (n > bound) begin
        num_errors++;
        $display("Error interrupt_out_n expected %b seen timeout", lvl);
        stop_test();
      end
    end
    check("interrupt_out_n", 48'(int_n), 48'(lvl));
  endtask : wait_int

  // main sequence
  initial begin
    repeat (12) @(negedge clk_sys_i);
    rst_i = 1'b0;
    check("interrupt_out_n", 48'(int_n), 48'h1);
    check("recovery_enable", 48'(rec_en), 48'h0);
    check("codes", codes, 48'h0);
    check("low_power", 48'(lp), 48'h0);
    $display("reset values done");
    rd(`MCEM_OFS_STATUS, 8'h01, "status before ready");
    wait_int(1'b0, INIT + 20);
    rd(`MCEM_OFS_STATUS, 8'h00, "status ready");
    wait_int(1'b1, 40);
    $display("init done");
    wr(`MCEM_OFS_PAGE, `MCEM_CODE_PAGE);
    foreach (rows[i]) begin
      wr(rows[i].ofs, rows[i].data);
      repeat (10) @(negedge clk_sys_i);
      check("recovery_enable", 48'(rec_en), 48'(rows[i].en));
      check("codes", codes, rows[i].codes);
      rd(rows[i].ofs, rows[i].data, "readback");
    end
    // upper bytes vanish when another page is selected
    wr(`MCEM_OFS_PAGE, 8'h00);
    rd(`MCEM_OFS_TX_EQ, 8'h00, "other page");
    wr(`MCEM_OFS_TX_EQ, 8'h55);
    repeat (10) @(negedge clk_sys_i);
    check("codes", codes, rows[9].codes);
    rd(8'h10, 8'h00, "unmapped");
    $display("register table done");
    // lock is lost briefly and back before the host reads
    foreach (pats[i]) begin
      @(negedge clk_sys_i);
      lock_lost = mcem_lane_bits_type'(pats[i]);
      repeat (5) @(negedge clk_sys_i);
      lock_lost = '0;
      wait_int(1'b0, 20);
      repeat (20) @(negedge clk_sys_i);
      rd(`MCEM_OFS_LOL, pats[i], "lock loss flags");
      wait_int(1'b1, 40);
      rd(`MCEM_OFS_LOL, 8'h00, "flags after read");
    end
    $display("lock loss done");
    @(negedge clk_sys_i);
    lp_pin = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    check("low_power", 48'(lp), 48'h1);
    lp_pin = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    check("low_power", 48'(lp), 48'h0);
    $display("low power done");
    // a frame for another device is not answered
    host.start();
    host.send({7'h51, 1'b0}, ack);
    host.stop();
    check("foreign address ack", 48'(ack), 48'h0);
    rd(`MCEM_OFS_CDR, 8'ha5, "after foreign frame");
    $display("refusal done");
    // a pulse shorter than the minimum is ignored
    @(negedge clk_sys_i);
    reset_in_n = 1'b0;
    repeat (20) @(negedge clk_sys_i);
    reset_in_n = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    rd(`MCEM_OFS_STATUS, 8'h00, "status after short pulse");
    @(negedge clk_sys_i);
    reset_in_n = 1'b0;
    repeat (100) @(negedge clk_sys_i);
    rd(`MCEM_OFS_STATUS, 8'h01, "status in module reset");
    @(negedge clk_sys_i);
    reset_in_n = 1'b1;
    wait_int(1'b0, INIT + 20);
    check("recovery_enable", 48'(rec_en), 48'ha5);
    rd(`MCEM_OFS_STATUS, 8'h00, "status ready again");
    wait_int(1'b1, 40);
    $display("module reset done");
    // system reset in mid-run: both domains restart and config bytes clear
    @(negedge clk_sys_i);
    rst_i = 1'b1;
    repeat (12) @(negedge clk_sys_i);
    rst_i = 1'b0;
    check("recovery_enable", 48'(rec_en), 48'h0);
    check("codes", codes, 48'h0);
    check("interrupt_out_n", 48'(int_n), 48'h1);
    rd(`MCEM_OFS_STATUS, 8'h01, "status after system reset");
    rd(`MCEM_OFS_CDR, 8'h00, "enables after system reset");
    wait_int(1'b0, INIT + 20);
    $display("system reset done");
    stop_test();
  end
endmodule : tb_module_cdr_eq_mgmt
